/* File: src/output_function_selector.v */
// Purpose: Drives each output line from its programmed function source.
// Assumes: AHB-Lite single word transfers; event inputs are one-cycle pulses
//          from logic on clk; door contact and bell pins are asynchronous.
// Notes:   Zero wait states; every response is OKAY.
`timescale 1ns/100ps
`include "out_sel_defs.vh"
module output_function_selector #(
  parameter SEC_CYC = `SEC_CYCLES,
  parameter NOUT    = 8
) (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output wire        hreadyout,
  output wire        hresp,
  // Controller state, same clock
  input  wire        armed,
  input  wire        preAlarm,
  input  wire        doorAjar,
  input  wire        forcedEntry,
  input  wire        accessGranted,
  input  wire        accessDenied,
  input  wire        entryTerminalId,
  input  wire        exitTerminalId,
  input  wire        bellKey,
  input  wire        normalMode,
  input  wire        unlockedMode,
  // Asynchronous pins
  input  wire        doorOpenPin,
  input  wire        bellPin,
  // Relays
  output reg         relayOutputFirst,
  output reg         relayOutputSecond,
  // Open-drain outputs, low when driven
  output wire        openDrainOutputFirstO,
  output reg         openDrainOutputFirstOe,
  output wire        openDrainOutputSecondO,
  output reg         openDrainOutputSecondOe,
  // Extension lines
  output reg         extOutputFirst,
  output reg         extOutputSecond,
  // Reader link lines as outputs
  output reg         readerLinkClockLine,
  output reg         readerLinkClockLineOe,
  output reg         readerLinkDataLine,
  output reg         readerLinkDataLineOe,
  // Buzzer
  output reg         buzzer
);
  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  reg [1:0] doorSync_q;
  reg [1:0] bellSync_q;
  reg       bellPrev_q;
  // Two stages before any logic reads the pins
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      doorSync_q <= 2'b00;
      bellSync_q <= 2'b00;
      bellPrev_q <= 1'b0;
    end else if (ce) begin
      doorSync_q <= {doorSync_q[0], doorOpenPin};
      bellSync_q <= {bellSync_q[0], bellPin};
      bellPrev_q <= bellSync_q[1];
    end
  end
  wire doorOpen = doorSync_q[1];
  wire bellLevel = bellSync_q[1];
  // Rising edge of bell line or a key press
  wire bellTrig = bellKey | (bellLevel & ~bellPrev_q);
  // ***************************************************
  // Registers
  // ***************************************************
  reg [`OS_CODE_W-1:0] code_q [0:NOUT-1];
  reg [15:0]           unlockSec_q;
  reg [1:0]            ctrl_q;
  reg                  apValid_q;
  reg                  apWrite_q;
  reg [11:0]           apAddr_q;
  wire                 apTake = hsel & hready & htrans[1];
  integer              i;
  // Address phase capture and register writes
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      apValid_q   <= 1'b0;
      apWrite_q   <= 1'b0;
      apAddr_q    <= 12'h000;
      unlockSec_q <= `OS_UNLOCK_RST;
      ctrl_q      <= 2'b00;
      for (i = 0; i < NOUT; i = i + 1)
        code_q[i] <= `OS_CODE_RST;
    end else if (ce) begin
      if (hready) begin
        apValid_q <= apTake;
        apWrite_q <= hwrite;
        apAddr_q  <= haddr;
      end
      if (apValid_q && apWrite_q) begin
        if (apAddr_q[11:5] == 7'h00)
          code_q[apAddr_q[4:2]] <= hwdata[`OS_CODE_W-1:0];
        else if (apAddr_q == `OS_ADDR_UNLOCK)
          unlockSec_q <= hwdata[15:0];
        else if (apAddr_q == `OS_ADDR_CTRL)
          ctrl_q <= hwdata[1:0];
      end
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  // ***************************************************
  // Event sources
  // ***************************************************
  wire tick;
  wire grantAct;
  wire deniedAct;
  wire bellAct;
  reg  logged_q;
  sec_tick #(.SEC_CYC(SEC_CYC)) uTick (
    .clk  (clk),
    .rstn (rstn),
    .ce   (ce),
    .tick (tick)
  );
  // Unlock time is software set, reloads on each grant
  sec_pulse uGrant (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .tick   (tick),
    .trig   (accessGranted),
    .secs   (unlockSec_q),
    .active (grantAct)
  );
  sec_pulse uDenied (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .tick   (tick),
    .trig   (accessDenied),
    .secs   (`PULSE_SEC),
    .active (deniedAct)
  );
  sec_pulse uBell (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .tick   (tick),
    .trig   (bellTrig),
    .secs   (`PULSE_SEC),
    .active (bellAct)
  );
  // Entry sets, exit clears; entry wins if both coincide
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      logged_q <= 1'b0;
    else if (ce) begin
      if (entryTerminalId)
        logged_q <= 1'b1;
      else if (exitTerminalId)
        logged_q <= 1'b0;
    end
  end
  // ***************************************************
  // Function multiplexer, one per line
  // ***************************************************
  reg  [NOUT-1:0] act_q;
  wire [NOUT-1:0] selVec;
  genvar g;
  generate
    for (g = 0; g < NOUT; g = g + 1) begin : gSel
      reg sel;
      always @* begin
        case (code_q[g])
          `FN_DISARMED:    sel = ~armed;
          `FN_PREALARM:    sel = preAlarm;
          `FN_AJAR:        sel = doorAjar;
          `FN_FORCED:      sel = forcedEntry;
          `FN_PRE_AJAR:    sel = preAlarm | doorAjar;
          `FN_PRE_FORCED:  sel = preAlarm | forcedEntry;
          `FN_AJAR_FORCED: sel = doorAjar | forcedEntry;
          `FN_ALL_ALARM:   sel = preAlarm | doorAjar | forcedEntry;
          `FN_GRANTED:     sel = grantAct;
          `FN_DOOR_STATUS: sel = doorOpen;
          `FN_DENIED:      sel = deniedAct;
          `FN_LOGGED:      sel = logged_q;
          `FN_BELL:        sel = bellAct;
          `FN_NORMAL_MODE: sel = normalMode;
          `FN_UNLOCK_MODE: sel = unlockedMode;
          default:         sel = 1'b0;
        endcase
      end
      assign selVec[g] = sel;
    end
  endgenerate
  // One process owns every activity bit
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      act_q <= {NOUT{1'b0}};
    else if (ce)
      act_q <= selVec;
  end
  // ***************************************************
  // Pin drivers
  // ***************************************************
  wire readerFree = ~ctrl_q[`OS_CTRL_READER] & ~ctrl_q[`OS_CTRL_EXT];
  assign openDrainOutputFirstO  = 1'b0;
  assign openDrainOutputSecondO = 1'b0;
  // Registered pins; lines 0..7 map relay1, od1, od2, relay2, ext, reader
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      relayOutputFirst        <= 1'b0;
      relayOutputSecond       <= 1'b0;
      openDrainOutputFirstOe  <= 1'b0;
      openDrainOutputSecondOe <= 1'b0;
      extOutputFirst          <= 1'b0;
      extOutputSecond         <= 1'b0;
      readerLinkClockLine     <= 1'b0;
      readerLinkClockLineOe   <= 1'b0;
      readerLinkDataLine      <= 1'b0;
      readerLinkDataLineOe    <= 1'b0;
      buzzer                  <= 1'b0;
    end else if (ce) begin
      relayOutputFirst        <= act_q[0];
      openDrainOutputFirstOe  <= act_q[1];
      openDrainOutputSecondOe <= act_q[2];
      relayOutputSecond       <= act_q[3];
      extOutputFirst  <= act_q[4] & ctrl_q[`OS_CTRL_EXT];
      extOutputSecond <= act_q[5] & ctrl_q[`OS_CTRL_EXT];
      readerLinkClockLine   <= act_q[6] & readerFree;
      readerLinkClockLineOe <= readerFree;
      readerLinkDataLine    <= act_q[7] & readerFree;
      readerLinkDataLineOe  <= readerFree;
      buzzer                <= bellLevel;
    end
  end
  // ***************************************************
  // Read data
  // ***************************************************
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      hrdata <= 32'h0000_0000;
    else if (ce && apTake && !hwrite) begin
      if (haddr[11:5] == 7'h00)
        hrdata <= {25'h0, code_q[haddr[4:2]]};
      else if (haddr == `OS_ADDR_UNLOCK)
        hrdata <= {16'h0000, unlockSec_q};
      else if (haddr == `OS_ADDR_CTRL)
        hrdata <= {30'h0000_0000, ctrl_q};
      else if (haddr == `OS_ADDR_STATUS)
        hrdata <= {23'h00_0000, logged_q, act_q};
      else
        hrdata <= 32'h0000_0000;
    end
  end
endmodule

/* File: inc/out_sel_defs.vh */
// Overview of operation
// - One relay, two open-drain lines; optional second relay, two extension lines.
// - Every output line holds its own programmable function code.
// - Open-drain outputs float when inactive and pull to ground when active.
// - Reader clock and data lines act as outputs when no reader and no extension lines attached.
// - Code 00: output active while disarmed, inactive while armed.
// - Codes 01, 02, 04 signal prealarm, door ajar, forced entry.
// - Codes 03, 05, 06, 07 signal OR of their constituent alarm conditions.
// - Code 09: active for door unlock time after each access grant.
// - Code 10: follows door contact, active while door open.
// - Code 11: two second pulse on each access denial.
// - Code 14: set by entry terminal identification, cleared by exit terminal.
// - Code 15: two second pulse on door bell, key or input.
// - Code 18: active while in normal door mode.
// - Code 19: active while in unlocked door mode.
// - Door bell input sounds buzzer and may drive door bell outputs.
//
// Purpose: Constants for the output function selector.
// Assumes: 50 MHz clock.
// Notes:   Function codes are decimal values in the code field.
`ifndef OUT_SEL_DEFS_VH
`define OUT_SEL_DEFS_VH
// ***************************************************
// Register map (byte addresses)
// ***************************************************
`define OS_ADDR_CODE0    12'h000
`define OS_ADDR_CODE1    12'h004
`define OS_ADDR_CODE2    12'h008
`define OS_ADDR_CODE3    12'h00C
`define OS_ADDR_CODE4    12'h010
`define OS_ADDR_CODE5    12'h014
`define OS_ADDR_CODE6    12'h018
`define OS_ADDR_CODE7    12'h01C
`define OS_ADDR_UNLOCK   12'h020
`define OS_ADDR_CTRL     12'h024
`define OS_ADDR_STATUS   12'h028
// ***************************************************
// Fields and reset values
// ***************************************************
`define OS_CODE_W        7
`define OS_CODE_RST      7'h7F
`define OS_CTRL_READER   0
`define OS_CTRL_EXT      1
`define OS_UNLOCK_RST    16'h0004
// ***************************************************
// Function codes
// ***************************************************
`define FN_DISARMED      7'd0
`define FN_PREALARM      7'd1
`define FN_AJAR          7'd2
`define FN_PRE_AJAR      7'd3
`define FN_FORCED        7'd4
`define FN_PRE_FORCED    7'd5
`define FN_AJAR_FORCED   7'd6
`define FN_ALL_ALARM     7'd7
`define FN_GRANTED       7'd9
`define FN_DOOR_STATUS   7'd10
`define FN_DENIED        7'd11
`define FN_LOGGED        7'd14
`define FN_BELL          7'd15
`define FN_NORMAL_MODE   7'd18
`define FN_UNLOCK_MODE   7'd19
// ***************************************************
// Timing
// ***************************************************
`define CLK_HZ           50000000
`define PULSE_SEC        16'd2
`define SEC_CYCLES       (`CLK_HZ)
`endif

/* File: src/sec_tick.v */
// Purpose: One-cycle tick once per second.
// Assumes: Clock enable freezes the count.
// Notes:   Period is a parameter so benches can shorten it.
`timescale 1ns/100ps
`include "out_sel_defs.vh"
module sec_tick #(
  parameter SEC_CYC = `SEC_CYCLES
) (
  // Clock and reset
  input  wire clk,
  input  wire rstn,
  input  wire ce,
  // Tick out
  output wire tick
);
  reg [31:0] cnt_q;
  // Free running divider
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      cnt_q <= 32'h0000_0000;
    else if (ce)
      cnt_q <= tick ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
  end
  assign tick = ce && (cnt_q == SEC_CYC - 1);
endmodule

/* File: src/sec_pulse.v */
// Purpose: Retriggerable pulse stretcher counted in seconds.
// Assumes: tick is one cycle per second.
// Notes:   Length up to one second short is possible; trade for one divider.
`timescale 1ns/100ps
module sec_pulse (
  // Clock and reset
  input  wire        clk,
  input  wire        rstn,
  input  wire        ce,
  // Trigger and length
  input  wire        tick,
  input  wire        trig,
  input  wire [15:0] secs,
  // Pulse out
  output wire        active
);
  reg [15:0] left_q;
  // Retrigger reloads full length
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      left_q <= 16'h0000;
    else if (ce) begin
      if (trig)
        left_q <= secs;
      else if (tick && left_q != 16'h0000)
        left_q <= left_q - 16'h0001;
    end
  end
  assign active = (left_q != 16'h0000);
endmodule

/* File: tb/out_sel_asserts.sv */
// Purpose: Port checks for the output function selector
// Assumes: ce held high by the bench
// Notes:   Shadows code0 from bus writes to judge the first relay
`timescale 1ns/100ps
`include "out_sel_defs.vh"
module out_sel_asserts (
  // Clock, reset and bus
  input wire        clk,
  input wire        rstn,
  input wire        hsel,
  input wire [11:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hwdata,
  // Sources
  input wire        armed,
  input wire        doorOpenPin,
  input wire        bellPin,
  // Outputs
  input wire        relayOutputFirst,
  input wire        relayOutputSecond,
  input wire        openDrainOutputFirstO,
  input wire        openDrainOutputFirstOe,
  input wire        openDrainOutputSecondO,
  input wire        readerLinkClockLineOe,
  input wire        readerLinkDataLineOe,
  input wire        buzzer
);
  reg       wrHit_q;
  reg [6:0] code_q;
  reg [1:0] age_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Age saturates at 3 so a flushed code is known
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrHit_q <= 1'b0;
      code_q  <= `OS_CODE_RST;
      age_q   <= 2'd0;
    end else begin
      wrHit_q <= hsel && hready && htrans[1] && hwrite &&
                 haddr == `OS_ADDR_CODE0;
      if (wrHit_q) begin
        code_q <= hwdata[6:0];
        age_q  <= 2'd0;
      end else if (age_q != 2'd3) begin
        age_q <= age_q + 2'd1;
      end
    end
  end
  // ****************************************
  // Line checks
  // ****************************************
  chk_od_first_low: assert property (
    openDrainOutputFirstO == 1'b0) else $error("od first drives high");
  chk_od_second_low: assert property (
    openDrainOutputSecondO == 1'b0) else $error("od second drives high");
  chk_reset_lines_idle: assert property (
    $rose(rstn) |-> !relayOutputFirst && !relayOutputSecond &&
    !openDrainOutputFirstOe && !buzzer) else $error("line on after reset");
  chk_buzzer_on: assert property (
    bellPin [*4] |-> buzzer) else $error("buzzer silent on bell");
  chk_buzzer_off: assert property (
    !bellPin [*4] |-> !buzzer) else $error("buzzer on without bell");
  chk_reader_oe_pair: assert property (
    readerLinkClockLineOe == readerLinkDataLineOe)
    else $error("reader enables differ");
  chk_disarmed_relay: assert property (
    code_q == `FN_DISARMED && age_q == 2'd3 && $past(armed) == armed &&
    $past(armed, 2) == armed |-> relayOutputFirst == !armed)
    else $error("relay not disarmed state");
  chk_unassigned_idle: assert property (
    age_q == 2'd3 && (code_q == 7'd8 || code_q == 7'd12 ||
    code_q == `OS_CODE_RST) |-> !relayOutputFirst)
    else $error("unassigned code drives relay");
  chk_door_relay: assert property (
    doorOpenPin [*5] ##0 (code_q == `FN_DOOR_STATUS && age_q == 2'd3)
    |-> relayOutputFirst) else $error("relay ignores door contact");
endmodule

/* File: tb/load_model.sv */
// Purpose: Loads on the open-drain and reader lines
// Assumes: Every line has a pull-up to the supply
// Notes:   A released line reads high, never the last value
`timescale 1ns/100ps
module load_model (
  // Drivers from the block
  input  wire odFirstO,
  input  wire odFirstOe,
  input  wire odSecondO,
  input  wire odSecondOe,
  input  wire rdClk,
  input  wire rdClkOe,
  input  wire rdData,
  input  wire rdDataOe,
  // Wire levels
  output wire odFirstLvl,
  output wire odSecondLvl,
  output wire rdClkLvl,
  output wire rdDataLvl
);
  // Pull-up wins whenever the driver lets go
  assign odFirstLvl  = odFirstOe ? odFirstO : 1'b1;
  assign odSecondLvl = odSecondOe ? odSecondO : 1'b1;
  assign rdClkLvl    = rdClkOe ? rdClk : 1'b1;
  assign rdDataLvl   = rdDataOe ? rdData : 1'b1;
endmodule

/* File: tb/testbench.sv */
// Purpose: Self-checking bench for the output function selector
// Assumes: One second shortened to 10 cycles
// Notes:   Register access over AHB-Lite single word transfers
`timescale 1ns/100ps
`include "out_sel_defs.vh"
module testbench;
  reg         clk, rstn, hsel, hwrite;
  reg  [11:0] haddr;
  reg  [1:0]  htrans;
  reg  [31:0] hwdata, q;
  reg         armed, preAlarm, doorAjar, forcedEntry, normalMode;
  reg         unlockedMode, doorOpenPin, bellPin;
  reg  [4:0]  ev;
  wire [31:0] hrdata;
  wire        hreadyout, hresp, relFirst, relSecond, buzzer;
  wire        odFirstO, odFirstOe, odSecondO, odSecondOe, extFirst;
  wire        rdClk, rdClkOe, rdData, rdDataOe;
  wire        odFirstLvl, odSecondLvl, rdClkLvl, rdDataLvl;
  integer     miscompares, compares, c, k;
  output_function_selector #(.SEC_CYC(10)) dut (
    .clk(clk), .rstn(rstn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .armed(armed), .preAlarm(preAlarm),
    .doorAjar(doorAjar), .forcedEntry(forcedEntry),
    .accessGranted(ev[0]), .accessDenied(ev[1]),
    .entryTerminalId(ev[2]), .exitTerminalId(ev[3]), .bellKey(ev[4]),
    .normalMode(normalMode), .unlockedMode(unlockedMode),
    .doorOpenPin(doorOpenPin), .bellPin(bellPin),
    .relayOutputFirst(relFirst), .relayOutputSecond(relSecond),
    .openDrainOutputFirstO(odFirstO), .openDrainOutputFirstOe(odFirstOe),
    .openDrainOutputSecondO(odSecondO),
    .openDrainOutputSecondOe(odSecondOe), .extOutputFirst(extFirst),
    .extOutputSecond(), .readerLinkClockLine(rdClk),
    .readerLinkClockLineOe(rdClkOe), .readerLinkDataLine(rdData),
    .readerLinkDataLineOe(rdDataOe), .buzzer(buzzer));
  load_model loads (
    .odFirstO(odFirstO), .odFirstOe(odFirstOe), .odSecondO(odSecondO),
    .odSecondOe(odSecondOe), .rdClk(rdClk), .rdClkOe(rdClkOe),
    .rdData(rdData), .rdDataOe(rdDataOe), .odFirstLvl(odFirstLvl),
    .odSecondLvl(odSecondLvl), .rdClkLvl(rdClkLvl), .rdDataLvl(rdDataLvl));
  // ****************************************
  // Bus and compare tasks
  // ****************************************
  task bus(input [11:0] a, input w, input [31:0] d);
    begin
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= w;
      htrans <= 2'b10;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      q = hrdata;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // One-cycle event pulse on the chosen source
  task pulse(input integer i);
    begin
      ev[i] <= 1'b1;
      @(posedge clk);
      ev <= 5'd0;
    end
  endtask
  task chk1(input [8*8:1] nm, input e, input g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch %0s expected %b seen %b", nm, e, g);
      end
    end
  endtask
  task chk32(input [8*8:1] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("mismatch %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    begin
      bus(`OS_ADDR_CODE0, 0, 0); chk32("code0", 32'h0000_007F, q);
      bus(`OS_ADDR_UNLOCK, 0, 0); chk32("unlock", 32'h0000_0004, q);
      bus(12'h03C, 0, 0); chk32("unmapped", 32'h0000_0000, q);
      chk1("relay1", 1'b0, relFirst);
      chk1("hresp", 1'b0, hresp);
      chk1("hready", 1'b1, hreadyout);
      $display("test reset done");
    end
  endtask
  // Alarm codes on od1, each code against every condition mix
  task t_alarm;
    begin
      for (c = 1; c < 8; c = c + 1) begin
        bus(`OS_ADDR_CODE1, 1, c);
        for (k = 0; k < 8; k = k + 1) begin
          {forcedEntry, doorAjar, preAlarm} <= k;
          cyc(3);
          chk1("od1lvl", ~|(c & k), odFirstLvl);
          chk1("od2lvl", 1'b1, odSecondLvl);
        end
      end
      {forcedEntry, doorAjar, preAlarm} <= 3'd0;
      $display("test alarm done");
    end
  endtask
  task t_levels;
    begin
      bus(`OS_ADDR_CODE0, 1, `FN_DISARMED);
      armed <= 1'b0; cyc(3); chk1("relay1", 1'b1, relFirst);
      armed <= 1'b1; cyc(3); chk1("relay1", 1'b0, relFirst);
      bus(`OS_ADDR_CODE0, 1, `FN_NORMAL_MODE);
      bus(`OS_ADDR_CODE3, 1, `FN_UNLOCK_MODE);
      normalMode <= 1'b1; cyc(3);
      chk1("relay1", 1'b1, relFirst);
      chk1("relay2", 1'b0, relSecond);
      normalMode <= 1'b0; unlockedMode <= 1'b1; cyc(3);
      chk1("relay1", 1'b0, relFirst);
      chk1("relay2", 1'b1, relSecond);
      bus(`OS_ADDR_CODE0, 1, 8); armed <= 1'b0; cyc(4);
      chk1("relay1", 1'b0, relFirst);
      bus(`OS_ADDR_CODE0, 1, 10); doorOpenPin <= 1'b1; cyc(5);
      chk1("relay1", 1'b1, relFirst);
      doorOpenPin <= 1'b0; cyc(5); chk1("relay1", 1'b0, relFirst);
      $display("test levels done");
    end
  endtask
  task t_pulses;
    begin
      bus(`OS_ADDR_CODE0, 1, `FN_DENIED); pulse(1); cyc(4);
      chk1("relay1", 1'b1, relFirst); cyc(20);
      chk1("relay1", 1'b0, relFirst);
      bus(`OS_ADDR_CODE0, 1, `FN_BELL); pulse(4); cyc(4);
      chk1("relay1", 1'b1, relFirst); cyc(20);
      chk1("relay1", 1'b0, relFirst);
      bellPin <= 1'b1; cyc(6); chk1("relay1", 1'b1, relFirst);
      chk1("buzzer", 1'b1, buzzer); bellPin <= 1'b0; cyc(25);
      chk1("relay1", 1'b0, relFirst); chk1("buzzer", 1'b0, buzzer);
      bus(`OS_ADDR_UNLOCK, 1, 5); bus(`OS_ADDR_CODE0, 1, `FN_GRANTED);
      pulse(0); cyc(40); chk1("relay1", 1'b1, relFirst);
      cyc(15); chk1("relay1", 1'b0, relFirst);
      bus(`OS_ADDR_CODE0, 1, `FN_LOGGED); pulse(2); cyc(15);
      chk1("relay1", 1'b1, relFirst); pulse(3); cyc(4);
      chk1("relay1", 1'b0, relFirst);
      $display("test pulses done");
    end
  endtask
  // Reader lines free only with nothing attached
  task t_lines;
    begin
      bus(`OS_ADDR_CTRL, 1, 0); cyc(3); chk1("rdOe", 1'b1, rdDataOe);
      bus(`OS_ADDR_CTRL, 1, 2); bus(`OS_ADDR_CODE4, 1, `FN_NORMAL_MODE);
      normalMode <= 1'b1; cyc(3);
      chk1("ext1", 1'b1, extFirst); chk1("rdOe", 1'b0, rdDataOe);
      bus(`OS_ADDR_CTRL, 1, 0); cyc(3); chk1("ext1", 1'b0, extFirst);
      bus(`OS_ADDR_CODE6, 1, `FN_NORMAL_MODE); cyc(3);
      chk1("rdClk", 1'b1, rdClkLvl);
      chk1("rdData", 1'b0, rdDataLvl);
      $display("test lines done");
    end
  endtask
  // ****************************************
  // Clock, reset, watchdog, sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #(20 * 8000);
    miscompares = miscompares + 1;
    wrap_up;
  end
  initial begin
    miscompares = 0; compares = 0; rstn = 1'b0; hsel = 1'b0; hwrite = 1'b0;
    haddr = 12'h000; htrans = 2'b00; hwdata = 32'h0000_0000; ev = 5'd0;
    {armed, preAlarm, doorAjar, forcedEntry, normalMode} = 5'd0;
    {unlockedMode, doorOpenPin, bellPin} = 3'd0;
    cyc(20);
    rstn <= 1'b1;
    cyc(1);
    t_reset;
    t_alarm;
    t_levels;
    t_pulses;
    t_lines;
    wrap_up;
  end
endmodule
bind output_function_selector out_sel_asserts chk (.clk, .rstn, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hwdata, .armed, .doorOpenPin,
  .bellPin, .relayOutputFirst, .relayOutputSecond, .openDrainOutputFirstO,
  .openDrainOutputFirstOe, .openDrainOutputSecondO, .readerLinkClockLineOe,
  .readerLinkDataLineOe, .buzzer);
